// ===== rtl/tdst_top.v
// tdst_top.v: time-of-day sequence timer with real-time clock and wishbone slave
// assumes: classic wishbone master on CLOCK_IN, synchronous active-high reset
//
// Function
// - start and stop times take hh:mm from 00:00 to 24:00 and reset to 00:00.
// - day code 0 off, 1 daily, 2 mon-fri, 3 weekend, 4..10 monday..sunday, reset 0.
// - action code 0 output only, 1 run request, 2 run request with pi off, reset 0.
// - reference code 0..3 operator presets, 4 terminals, 5 serial, 6 option card, reset 0.
// - the reference selection is applied only for action codes 1 and 2.
// - a settable real-time clock holds day of week and time and feeds the compare.
// - slots of later timers follow the first from index 320b, five fields each, but hold no storage and read zero.
//
// The Wishbone slave port was chosen for this implementation.
`include "tdst_map.vh"

module tdst_top #(
  parameter SEC_CYCLES = `TDST_SEC_CYCLES,
  parameter NUM_TIMERS = 1
) (
  input  wire        CLOCK_IN,
  input  wire        RST_IN,
  input  wire        WB_CYC_IN,
  input  wire        WB_STB_IN,
  input  wire        WB_WE_IN,
  input  wire [17:0] WB_ADR_IN,
  input  wire [3:0]  WB_SEL_IN,
  input  wire [31:0] WB_DAT_IN,
  output reg  [31:0] WB_DAT_OUT,
  output reg         WB_ACK_OUT,
  output reg         TIMER_ACTIVE_OUT,
  output reg         DIGITAL_OUT,
  output reg         RUN_REQUEST_OUT,
  output reg         PI_DISABLE_OUT,
  output reg         REF_OVERRIDE_OUT,
  output reg  [2:0]  REF_SOURCE_OUT
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg  [15:0] start_time_reg;
  reg  [15:0] stop_time_reg;
  reg  [3:0]  day_select_reg;
  reg  [1:0]  action_select_reg;
  reg  [2:0]  ref_source_reg;
  reg  [31:0] sec_cnt_reg;
  reg         sec_tick_reg;
  reg         clk_load_reg;
  reg  [4:0]  load_hour_reg;
  reg  [5:0]  load_min_reg;
  reg  [5:0]  load_sec_reg;
  reg  [2:0]  load_dow_reg;
  reg  [15:0] clock_set_control_reg;
  reg  [31:0] rd_next;
  reg         day_match_next;
  reg         time_ok_next;
  wire [4:0]  rtc_hour;
  wire [5:0]  rtc_min;
  wire [5:0]  rtc_sec;
  wire [2:0]  rtc_dow;
  wire [15:0] idx;
  wire        req;
  wire        wr_en;
  wire [15:0] wd;
  wire [10:0] now_min;
  wire [10:0] start_min;
  wire [10:0] stop_min;
  wire        active_now;
  wire        time_field_ok;
  wire [4:0]  wd_hour;
  wire [5:0]  wd_min;
  wire [15:0] fld_off;
  wire        tmr_space;
  wire        tmr_later;
  wire        day_ok;
  wire        act_ok;
  wire        ref_ok;
  wire        clk_hm_ok;
  wire        clk_ds_ok;
  wire [14:0] cmp_hour;
  wire [17:0] cmp_min;
  wire [32:0] cmp_tod;
  genvar      g;

  // ------------------------------------------------------------
  // bus decode: word index from byte address, low half in lanes 0 and 1
  // ------------------------------------------------------------
  assign idx     = WB_ADR_IN[17:2];
  assign req     = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  assign wr_en   = req & WB_WE_IN & WB_SEL_IN[0] & WB_SEL_IN[1];
  assign wd      = WB_DAT_IN[15:0];
  assign wd_hour = wd[`TDST_HOUR_MSB:`TDST_HOUR_LSB];
  assign wd_min  = wd[`TDST_MIN_MSB:`TDST_MIN_LSB];
  // times accepted only up to 24:00, minutes up to 59
  assign time_field_ok = (wd_hour < `TDST_MAX_HOUR && wd_min <= `TDST_MAX_MIN) ||
                         (wd_hour == `TDST_MAX_HOUR && wd_min == 6'h00);
  // range checks for the select codes and the clock staging words
  assign day_ok    = (wd <= {12'h000, `TDST_DAY_MAX});
  assign act_ok    = (wd <= {14'h0, `TDST_ACT_RUN_NOPI});
  assign ref_ok    = (wd <= {13'h0, `TDST_REF_MAX});
  assign clk_hm_ok = (wd_hour < `TDST_MAX_HOUR) && (wd_min <= `TDST_MAX_MIN);
  assign clk_ds_ok = (wd[`TDST_DOW_MSB:`TDST_DOW_LSB] <= 3'h6) && (wd_min <= `TDST_MAX_MIN);

  // ------------------------------------------------------------
  // timer field space: timer n owns the five indices from start + 5n
  // ------------------------------------------------------------
  // only the first timer holds storage; slots of later timers read zero
  assign fld_off   = idx - `TDST_IDX_START;
  assign tmr_space = (idx >= `TDST_IDX_START) && ({16'h0000, fld_off} < NUM_TIMERS * `TDST_FIELDS);
  assign tmr_later = tmr_space && (fld_off >= `TDST_FIELDS);

  // ------------------------------------------------------------
  // one-second enable from the system clock
  // ------------------------------------------------------------
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sec_cnt_reg  <= 32'h00000000;
      sec_tick_reg <= 1'b0;
    end else if (sec_cnt_reg == SEC_CYCLES - 1) begin
      sec_cnt_reg  <= 32'h00000000;
      sec_tick_reg <= 1'b1;
    end else begin
      sec_cnt_reg  <= sec_cnt_reg + 32'h00000001;
      sec_tick_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // real-time clock
  // ------------------------------------------------------------
  tdst_rtc u_rtc (
    .clk_in       (CLOCK_IN),
    .rst_in       (RST_IN),
    .tick_in      (sec_tick_reg),
    .load_in      (clk_load_reg),
    .load_hour_in (load_hour_reg),
    .load_min_in  (load_min_reg),
    .load_sec_in  (load_sec_reg),
    .load_dow_in  (load_dow_reg),
    .hour_out     (rtc_hour),
    .min_out      (rtc_min),
    .sec_out      (rtc_sec),
    .dow_out      (rtc_dow)
  );

  // ------------------------------------------------------------
  // register writes; out-of-range values are ignored
  // ------------------------------------------------------------
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      start_time_reg        <= `TDST_RST_TIME;
      stop_time_reg         <= `TDST_RST_TIME;
      day_select_reg        <= `TDST_DAY_OFF;
      action_select_reg     <= `TDST_ACT_DOUT;
      ref_source_reg        <= 3'h0;
      clk_load_reg          <= 1'b0;
      load_hour_reg         <= 5'h00;
      load_min_reg          <= 6'h00;
      load_sec_reg          <= 6'h00;
      load_dow_reg          <= 3'h0;
      clock_set_control_reg <= `TDST_RST_SEL;
    end else begin
      clk_load_reg <= 1'b0;
      if (wr_en) begin
        case (idx)
          `TDST_IDX_START: begin
            if (time_field_ok) start_time_reg <= {3'h0, wd_hour, 2'h0, wd_min};
          end
          `TDST_IDX_STOP: begin
            if (time_field_ok) stop_time_reg <= {3'h0, wd_hour, 2'h0, wd_min};
          end
          `TDST_IDX_DAY: begin
            if (day_ok) day_select_reg <= wd[3:0];
          end
          `TDST_IDX_ACTION: begin
            if (act_ok) action_select_reg <= wd[1:0];
          end
          `TDST_IDX_REFSRC: begin
            if (ref_ok) ref_source_reg <= wd[2:0];
          end
          `TDST_IDX_CLK_HM: begin
            if (clk_hm_ok) begin
              load_hour_reg <= wd_hour;
              load_min_reg  <= wd_min;
            end
          end
          `TDST_IDX_CLK_DS: begin
            if (clk_ds_ok) begin
              load_dow_reg <= wd[`TDST_DOW_MSB:`TDST_DOW_LSB];
              load_sec_reg <= wd_min;
            end
          end
          `TDST_IDX_CLK_CTRL: begin
            // writing 1 loads the staged time into the clock
            clock_set_control_reg <= {15'h0, wd[0]};
            clk_load_reg          <= wd[0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // activity compare in minutes of the day
  // ------------------------------------------------------------
  // slot 0 is the clock, 1 the start time, 2 the stop time
  assign cmp_hour = {stop_time_reg[12:8], start_time_reg[12:8], rtc_hour};
  assign cmp_min  = {stop_time_reg[5:0], start_time_reg[5:0], rtc_min};

  // hours times 60 as hours times 64 minus hours times 4
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tod
      assign cmp_tod[g*11 +: 11] = {cmp_hour[g*5 +: 5], 6'h00} - {4'h0, cmp_hour[g*5 +: 5], 2'h0} +
                                   {5'h00, cmp_min[g*6 +: 6]};
    end
  endgenerate
  assign now_min   = cmp_tod[10:0];
  assign start_min = cmp_tod[21:11];
  assign stop_min  = cmp_tod[32:22];

  // day decode, monday is dow 0
  always @* begin
    day_match_next = 1'b0;
    case (day_select_reg)
      `TDST_DAY_OFF:      day_match_next = 1'b0;
      `TDST_DAY_DAILY:    day_match_next = 1'b1;
      `TDST_DAY_WEEKDAYS: day_match_next = (rtc_dow <= 3'h4);
      `TDST_DAY_WEEKEND:  day_match_next = (rtc_dow >= 3'h5);
      default: begin
        day_match_next = (day_select_reg <= `TDST_DAY_MAX) &&
                         ({1'b0, rtc_dow} == day_select_reg - `TDST_DAY_MONDAY);
      end
    endcase
  end

  // start inclusive, stop exclusive, relies on start <= stop
  always @* begin
    time_ok_next = (now_min >= start_min) && (now_min < stop_min);
  end

  assign active_now = day_match_next & time_ok_next;

  // ------------------------------------------------------------
  // action outputs, all registered
  // ------------------------------------------------------------
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      TIMER_ACTIVE_OUT <= 1'b0;
      DIGITAL_OUT      <= 1'b0;
      RUN_REQUEST_OUT  <= 1'b0;
      PI_DISABLE_OUT   <= 1'b0;
      REF_OVERRIDE_OUT <= 1'b0;
      REF_SOURCE_OUT   <= 3'h0;
    end else begin
      TIMER_ACTIVE_OUT <= active_now;
      DIGITAL_OUT      <= active_now;
      RUN_REQUEST_OUT  <= active_now && (action_select_reg != `TDST_ACT_DOUT);
      PI_DISABLE_OUT   <= active_now && (action_select_reg == `TDST_ACT_RUN_NOPI);
      REF_OVERRIDE_OUT <= active_now && (action_select_reg != `TDST_ACT_DOUT);
      REF_SOURCE_OUT   <= (active_now && action_select_reg != `TDST_ACT_DOUT) ?
                          ref_source_reg : 3'h0;
    end
  end

  // ------------------------------------------------------------
  // read mux; unmapped and further-timer indices read zero
  // ------------------------------------------------------------
  always @* begin
    rd_next = 32'h00000000;
    case (idx)
      `TDST_IDX_START:    rd_next = {16'h0000, start_time_reg};
      `TDST_IDX_STOP:     rd_next = {16'h0000, stop_time_reg};
      `TDST_IDX_DAY:      rd_next = {28'h0000000, day_select_reg};
      `TDST_IDX_ACTION:   rd_next = {30'h0, action_select_reg};
      `TDST_IDX_REFSRC:   rd_next = {29'h0, ref_source_reg};
      `TDST_IDX_CLK_HM:   rd_next = {19'h0, rtc_hour, 2'h0, rtc_min};
      `TDST_IDX_CLK_DS:   rd_next = {21'h0, rtc_dow, 2'h0, rtc_sec};
      `TDST_IDX_CLK_CTRL: rd_next = {16'h0000, clock_set_control_reg};
      `TDST_IDX_STATUS:   rd_next = {26'h0, REF_OVERRIDE_OUT, PI_DISABLE_OUT, RUN_REQUEST_OUT,
                                     DIGITAL_OUT, day_match_next, TIMER_ACTIVE_OUT};
      default:            rd_next = 32'h00000000;
    endcase
    if (tmr_later) rd_next = 32'h00000000;
  end

  // ------------------------------------------------------------
  // ack one cycle after the request, dropped the next cycle
  // ------------------------------------------------------------
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h00000000;
    end else begin
      WB_ACK_OUT <= req;
      if (req && !WB_WE_IN) WB_DAT_OUT <= rd_next;
    end
  end

endmodule

// ===== rtl/tdst_map.vh
// tdst_map.vh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the timer design files
`ifndef TDST_MAP_VH
`define TDST_MAP_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define TDST_IDX_START      16'h3206
`define TDST_IDX_STOP       16'h3207
`define TDST_IDX_DAY        16'h3208
`define TDST_IDX_ACTION     16'h3209
`define TDST_IDX_REFSRC     16'h320a
`define TDST_IDX_TIMER2     16'h320b
`define TDST_IDX_CLK_HM     16'h3300
`define TDST_IDX_CLK_DS     16'h3301
`define TDST_IDX_CLK_CTRL   16'h3302
`define TDST_IDX_STATUS     16'h3303
`define TDST_FIELDS         16'h0005

// ------------------------------------------------------------
// field layout: time as hour in [12:8], minute in [5:0]
// ------------------------------------------------------------
`define TDST_HOUR_MSB       12
`define TDST_HOUR_LSB       8
`define TDST_MIN_MSB        5
`define TDST_MIN_LSB        0
`define TDST_MAX_HOUR       5'h18
`define TDST_MAX_MIN        6'h3b
`define TDST_DOW_MSB        10
`define TDST_DOW_LSB        8

// ------------------------------------------------------------
// codes and reset values
// ------------------------------------------------------------
`define TDST_DAY_OFF        4'h0
`define TDST_DAY_DAILY      4'h1
`define TDST_DAY_WEEKDAYS   4'h2
`define TDST_DAY_WEEKEND    4'h3
`define TDST_DAY_MONDAY     4'h4
`define TDST_DAY_MAX        4'ha
`define TDST_ACT_DOUT       2'h0
`define TDST_ACT_RUN        2'h1
`define TDST_ACT_RUN_NOPI   2'h2
`define TDST_REF_MAX        3'h6
`define TDST_RST_TIME       16'h0000
`define TDST_RST_SEL        16'h0000

// ------------------------------------------------------------
// timing: clock rate and one second of time of day
// ------------------------------------------------------------
`define TDST_CLK_HZ         100000000
`define TDST_SEC_NS         1000000000
`define TDST_CLK_NS         10
`define TDST_SEC_CYCLES     (`TDST_SEC_NS / `TDST_CLK_NS)

`endif

// ===== rtl/tdst_rtc.v
// tdst_rtc.v: time-of-day clock with seconds, minutes, hours and day of week
// assumes: one clock, a one-cycle second tick from the parent, synchronous reset
`include "tdst_map.vh"

module tdst_rtc (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        tick_in,
  input  wire        load_in,
  input  wire [4:0]  load_hour_in,
  input  wire [5:0]  load_min_in,
  input  wire [5:0]  load_sec_in,
  input  wire [2:0]  load_dow_in,
  output reg  [4:0]  hour_out,
  output reg  [5:0]  min_out,
  output reg  [5:0]  sec_out,
  output reg  [2:0]  dow_out
);

  // ------------------------------------------------------------
  // counting: dow 0 is monday, 6 is sunday
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      hour_out <= 5'h00;
      min_out  <= 6'h00;
      sec_out  <= 6'h00;
      dow_out  <= 3'h0;
    end else if (load_in) begin
      hour_out <= load_hour_in;
      min_out  <= load_min_in;
      sec_out  <= load_sec_in;
      dow_out  <= load_dow_in;
    end else if (tick_in) begin
      if (sec_out != 6'h3b) begin
        sec_out <= sec_out + 6'h01;
      end else begin
        sec_out <= 6'h00;
        if (min_out != `TDST_MAX_MIN) begin
          min_out <= min_out + 6'h01;
        end else begin
          min_out <= 6'h00;
          if (hour_out != 5'h17) begin
            hour_out <= hour_out + 5'h01;
          end else begin
            hour_out <= 5'h00;
            dow_out  <= (dow_out == 3'h6) ? 3'h0 : dow_out + 3'h1;
          end
        end
      end
    end
  end

endmodule

// ===== tb/tdst_sva.sv
// tdst_sva.sv: port checks for the sequence timer top
// assumes: bound to tdst_top, one clock, synchronous active-high reset
module tdst_sva #(
  parameter SEC_CYCLES = 4
) (
  input wire logic       CLOCK_IN,
  input wire logic       RST_IN,
  input wire logic       WB_CYC_IN,
  input wire logic       WB_STB_IN,
  input wire logic       WB_ACK_OUT,
  input wire logic       TIMER_ACTIVE_OUT,
  input wire logic       DIGITAL_OUT,
  input wire logic       RUN_REQUEST_OUT,
  input wire logic       PI_DISABLE_OUT,
  input wire logic       REF_OVERRIDE_OUT,
  input wire logic [2:0] REF_SOURCE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // bus answer timing
  property p_ack_next;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    WB_ACK_OUT |=> !WB_ACK_OUT;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // action outputs follow the active level
  property p_dout;
    DIGITAL_OUT == TIMER_ACTIVE_OUT;
  endproperty
  a_dout: assert property (p_dout) else $error("digital out wrong");
  property p_run;
    RUN_REQUEST_OUT |-> TIMER_ACTIVE_OUT;
  endproperty
  a_run: assert property (p_run) else $error("run while idle");
  property p_pi;
    PI_DISABLE_OUT |-> RUN_REQUEST_OUT;
  endproperty
  a_pi: assert property (p_pi) else $error("pi off without run");
  property p_ovr;
    REF_OVERRIDE_OUT == RUN_REQUEST_OUT;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override mismatch");
  property p_src;
    !REF_OVERRIDE_OUT |-> REF_SOURCE_OUT == 3'h0;
  endproperty
  a_src: assert property (p_src) else $error("source without override");
  property p_src_max;
    REF_SOURCE_OUT <= 3'h6;
  endproperty
  a_src_max: assert property (p_src_max) else $error("source code high");
  property p_rst;
    $fell(RST_IN) |-> !TIMER_ACTIVE_OUT && !WB_ACK_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
endmodule

bind tdst_top tdst_sva #(.SEC_CYCLES(SEC_CYCLES)) u_sva (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_ACK_OUT(WB_ACK_OUT), .TIMER_ACTIVE_OUT(TIMER_ACTIVE_OUT), .DIGITAL_OUT(DIGITAL_OUT),
  .RUN_REQUEST_OUT(RUN_REQUEST_OUT), .PI_DISABLE_OUT(PI_DISABLE_OUT),
  .REF_OVERRIDE_OUT(REF_OVERRIDE_OUT), .REF_SOURCE_OUT(REF_SOURCE_OUT));

// ===== tb/tdst_drive_model.sv
// tdst_drive_model.sv: drive sequencing that acts on the timer requests
// assumes: same clock as the timer, requests sampled on the rising edge
module tdst_drive_model #(
  parameter logic [2:0] NORMAL_REF = 3'h4
) (
  input  wire logic       clk_in,
  input  wire logic       run_in,
  input  wire logic       pi_off_in,
  input  wire logic       ovr_in,
  input  wire logic [2:0] src_in,
  output logic            motor_on_out,
  output logic            pi_on_out,
  output logic [2:0]      ref_used_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // follow the timer requests one cycle later
  always @(posedge clk_in) begin
    motor_on_out <= run_in;
    pi_on_out    <= run_in && !pi_off_in;
    ref_used_out <= ovr_in ? src_in : NORMAL_REF;
  end
endmodule

// ===== tb/tdst_tb.sv
// tdst_tb.sv: self-checking bench for the sequence timer
// assumes: tdst_top, tdst_drive_model and tdst_sva compiled before it
`include "tdst_map.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, cyc, stb, we, ack;
  logic        act, dout, run, pi, ovr, m_run, m_pion;
  logic [2:0]  src, m_ref;
  logic [17:0] adr;
  logic [3:0]  sel;
  logic [31:0] dwr, drd, q, seed;
  int          failures, comparisons, cycles, rs;
  logic [15:0] r_idx [8] = '{16'h3206, 16'h3207, 16'h3206, 16'h3206, 16'h3208, 16'h3209, 16'h320a, 16'h320b};
  logic [15:0] r_val [8] = '{16'h1801, 16'h1800, 16'h173b, 16'h0000, 16'h000b, 16'h0003, 16'h0007, 16'h1234};
  logic [15:0] r_exp [8] = '{16'h0000, 16'h1800, 16'h173b, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int          w_st [3] = '{600, 600, 601};
  int          w_sp [3] = '{1440, 600, 1440};

  tdst_top #(.SEC_CYCLES(4)) uut (.CLOCK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dwr), .WB_DAT_OUT(drd), .WB_ACK_OUT(ack),
    .TIMER_ACTIVE_OUT(act), .DIGITAL_OUT(dout), .RUN_REQUEST_OUT(run), .PI_DISABLE_OUT(pi),
    .REF_OVERRIDE_OUT(ovr), .REF_SOURCE_OUT(src));
  tdst_drive_model u_drive (.clk_in(clk), .run_in(run), .pi_off_in(pi), .ovr_in(ovr), .src_in(src),
    .motor_on_out(m_run), .pi_on_out(m_pion), .ref_used_out(m_ref));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] tm(input int m);
    return {3'h0, 5'(m / 60), 2'h0, 6'(m % 60)};
  endfunction
  // expected {active, dout, run, pi off, override, source}
  function automatic logic [7:0] expect_out(int dy, int dw, int ac, int r, int now, int st, int sp);
    logic a;
    a = dy == 1 || (dy == 2 && dw < 5) || (dy == 3 && dw > 4) || (dy > 3 && dy - 4 == dw);
    a = a && st <= now && now < sp;
    return {a, a, a && ac != 0, a && ac == 2, a && ac != 0, (a && ac != 0) ? 3'(r) : 3'h0};
  endfunction
  // one classic bus cycle, waits for ack
  task automatic wb(input logic [15:0] idx, input logic w, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hf;
    adr <= {idx, 2'b00};
    dwr <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = drd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic set_clock(input logic [2:0] dw);
    wb(`TDST_IDX_CLK_HM, 1'b1, 16'h0a00);
    wb(`TDST_IDX_CLK_DS, 1'b1, {5'h00, dw, 8'h00});
    wb(`TDST_IDX_CLK_CTRL, 1'b1, 16'h0001);
    wb(`TDST_IDX_CLK_HM, 1'b0, 16'h0000);
    `CHK("clock", 11'h280, {q[12:8], q[5:0]})
  endtask
  task automatic prog(input int st, sp, dy, ac, r);
    wb(`TDST_IDX_STOP, 1'b1, tm(sp));
    wb(`TDST_IDX_START, 1'b1, tm(st));
    wb(`TDST_IDX_DAY, 1'b1, 16'(dy));
    wb(`TDST_IDX_ACTION, 1'b1, 16'(ac));
    wb(`TDST_IDX_REFSRC, 1'b1, 16'(r));
  endtask
  task automatic chk_zero;
    for (int i = 0; i < 5; i++) begin
      wb(16'(`TDST_IDX_START + i), 1'b0, 16'h0000);
      `CHK("reset value", 32'h0, q)
    end
  endtask
  task automatic chk(input logic [7:0] e);
    repeat (3) @(posedge clk);
    #1;
    `CHK("outputs", e, {act, dout, run, pi, ovr, src})
    `CHK("drive ref", e[3] ? e[2:0] : 3'h4, m_ref)
    `CHK("drive run", {e[5], e[5] & ~e[4]}, {m_run, m_pion})
    wb(`TDST_IDX_STATUS, 1'b0, 16'h0000);
    `CHK("status", {e[3], e[4], e[5], e[6], e[7]}, {q[5:2], q[0]})
  endtask
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, timeout and sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    {rst, cyc, stb, we, adr, sel, dwr} = {1'b1, 3'h0, 18'h0, 4'hf, 32'h0};
    seed = 32'he229d5b8;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk_zero;
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      wb(r_idx[i], 1'b1, r_val[i]);
      wb(r_idx[i], 1'b0, 16'h0000);
      `CHK("range", {16'h0, r_exp[i]}, q)
    end
    $display("test ranges done");
    for (int k = 0; k < 2; k++) begin
      set_clock(3'(k * 5));
      for (int d = 0; d < 11; d++) begin
        for (int a = 0; a < 3; a++) begin
          seed = lfsr(seed);
          rs = int'(seed % 7);
          prog(540, 660, d, a, rs);
          chk(expect_out(d, k * 5, a, rs, 600, 540, 660));
        end
      end
    end
    $display("test day and action codes done");
    set_clock(3'h0);
    for (int i = 0; i < 3; i++) begin
      prog(w_st[i], w_sp[i], 1, 2, 5);
      chk(expect_out(1, 0, 2, 5, 600, w_st[i], w_sp[i]));
    end
    $display("test window edges done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_zero;
    chk(8'h00);
    $display("test mid-run reset done");
    wb(`TDST_IDX_CLK_HM, 1'b1, 16'h173b);
    wb(`TDST_IDX_CLK_DS, 1'b1, 16'h063b);
    wb(`TDST_IDX_CLK_CTRL, 1'b1, 16'h0001);
    repeat (8) @(posedge clk);
    wb(`TDST_IDX_CLK_HM, 1'b0, 16'h0000);
    `CHK("midnight", 32'h0, q)
    wb(`TDST_IDX_CLK_DS, 1'b0, 16'h0000);
    `CHK("new day", 3'h0, q[10:8])
    $display("test midnight rollover done");
    give_verdict;
  end
endmodule
